/* File: core/pmt_divider.sv */
// Programmable divide-by-(terminal+1) counter with synchronous clear.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/1ps
module pmt_divider
    import pmt_pkg::*;
#(
    parameter int WIDTH = 6
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clear,
    input wire logic tick,
    input wire logic [WIDTH-1:0] terminal,
    output logic done
);
    logic [WIDTH-1:0] cnt;
    logic [WIDTH-1:0] next_cnt;

    always_comb begin
        next_cnt = cnt;
        done = 1'b0;
        if (clear) begin
            next_cnt = '0;
        end else if (tick) begin
            if (cnt >= terminal) begin
                next_cnt = '0;
                done = 1'b1;
            end else begin
                next_cnt = cnt + WIDTH'(1);
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= '0;
        end else begin
            cnt <= next_cnt;
        end
    end
endmodule // pmt_divider

/* File: core/pmt_timer.sv */
// Eight-bit period match timer with input and output dividers, APB slave.
// Assumes pclk is the instruction clock; sleep_req comes from the same domain.
//
// Contract
// R1 - Sleep stops counting, matches and flags
// R2 - Count and period held during sleep
// R3 - Output divider field bits 6..3, ratio N+1
// R4 - Run bit at control bit 2
// R5 - Input divider bits 1..0: 1,4,16,64
// R6 - Control bit 7 reads zero, ignores writes
// R7 - Control bits read/write, reset to zero
// R8 - Count increments, wraps on period match
// R9 - Output divider completion sets match flag
// R10 - Reset clears count, period to all ones
// R11 - Count/control writes clear both dividers
// R12 - Run off holds count, no matches
`timescale 1ns/1ps
module pmt_timer
    import pmt_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sleep_req,
    output logic match_out,
    output logic irq
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [6:0] timer_control;
    logic [7:0] timer_period;
    logic [7:0] count_value;
    logic match_flag;
    logic match_irq_enable;
    logic [31:0] rdata_q;
    logic slverr_q;
    logic match_q;
    logic irq_q;
    logic [6:0] next_control;
    logic [7:0] next_period;
    logic [7:0] next_count;
    logic next_flag;
    logic next_irq_enable;
    logic [31:0] next_rdata;
    logic next_slverr;
    logic next_match;
    logic ready_q;
    logic next_ready;
    logic next_irq;

    logic setup;
    logic access;
    logic wr;
    logic rd;
    logic known;
    logic div_clear;
    logic active;
    logic in_tick;
    logic match_now;
    logic out_done;
    logic [5:0] in_terminal;
    logic timer_run;
    logic [1:0] input_divider_select;
    logic [3:0] output_divider_select;

    assign setup = psel && !penable;
    assign access = psel && penable && ready_q;
    assign wr = access && pwrite;
    assign rd = access && !pwrite;
    assign known = (paddr == PMT_ADDR_CONTROL) || (paddr == PMT_ADDR_PERIOD) ||
                   (paddr == PMT_ADDR_COUNT) || (paddr == PMT_ADDR_STATUS) ||
                   (paddr == PMT_ADDR_IRQ_EN) || (paddr == PMT_ADDR_IRQ_CLR);

    assign timer_run = timer_control[PMT_RUN_BIT]; // [R4]
    assign input_divider_select = timer_control[PMT_INDIV_MSB:PMT_INDIV_LSB];
    assign output_divider_select = timer_control[PMT_OUTDIV_MSB:PMT_OUTDIV_LSB];

    // ------------------------------------------------------------
    // Divider chain
    // ------------------------------------------------------------
    // Writes to count or control restart both dividers
    assign div_clear = wr && ((paddr == PMT_ADDR_CONTROL) || (paddr == PMT_ADDR_COUNT)); // [R11]
    // Sleep and run-off gate every tick at its source
    assign active = timer_run && !sleep_req; // [R1] [R12]

    always_comb begin
        case (input_divider_select) // [R5]
            2'b00: in_terminal = PMT_INDIV_TC_1;
            2'b01: in_terminal = PMT_INDIV_TC_4;
            2'b10: in_terminal = PMT_INDIV_TC_16;
            default: in_terminal = PMT_INDIV_TC_64;
        endcase
    end

    pmt_divider #(.WIDTH(6)) u_in_div (
        .pclk(pclk),
        .presetn(presetn),
        .clear(div_clear),
        .tick(active),
        .terminal(in_terminal),
        .done(in_tick)
    );

    // Compare is made on the divided edge, so a count written equal to the
    // period still wraps one divided tick later.
    assign match_now = in_tick && (count_value == timer_period); // [R8]

    pmt_divider #(.WIDTH(4)) u_out_div (
        .pclk(pclk),
        .presetn(presetn),
        .clear(div_clear),
        .tick(match_now),
        .terminal(output_divider_select), // [R3]
        .done(out_done)
    );

    // ------------------------------------------------------------
    // Register next values
    // ------------------------------------------------------------
    always_comb begin
        next_control = timer_control;
        next_period = timer_period;
        next_count = count_value;
        next_flag = match_flag;
        next_irq_enable = match_irq_enable;
        next_match = match_now;
        if (in_tick) begin
            next_count = match_now ? 8'h00 : count_value + 8'h01; // [R8]
        end
        if (wr) begin
            case (paddr)
                PMT_ADDR_CONTROL: next_control = pwdata[6:0] & PMT_CONTROL_MASK; // [R6] [R7]
                PMT_ADDR_PERIOD: next_period = pwdata[7:0];
                PMT_ADDR_COUNT: next_count = pwdata[7:0];
                PMT_ADDR_IRQ_EN: next_irq_enable = pwdata[0];
                PMT_ADDR_IRQ_CLR: next_flag = match_flag && !pwdata[0];
                default: next_flag = match_flag;
            endcase
        end
        // Set wins over a clear in the same cycle
        if (out_done) begin
            next_flag = 1'b1; // [R9]
        end
        next_irq = next_flag && next_irq_enable; // [R9]
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_control <= PMT_CONTROL_RESET; // [R7]
            timer_period <= PMT_PERIOD_RESET; // [R10]
            count_value <= PMT_COUNT_RESET; // [R10]
            match_flag <= 1'b0;
            match_irq_enable <= 1'b0;
            match_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            timer_control <= next_control;
            timer_period <= next_period;
            count_value <= next_count;
            match_flag <= next_flag;
            match_irq_enable <= next_irq_enable;
            match_q <= next_match;
            irq_q <= next_irq;
        end
    end

    // ------------------------------------------------------------
    // Bus response
    // ------------------------------------------------------------
    // Decoded in the setup cycle and registered, so every bus output leaves a
    // flip-flop; a read returns the value one cycle before the access edge.
    always_comb begin
        next_ready = setup;
        next_slverr = setup && !known;
        next_rdata = rdata_q;
        if (setup && !pwrite) begin
            case (paddr)
                PMT_ADDR_CONTROL: next_rdata = {25'h0000000, timer_control}; // [R6]
                PMT_ADDR_PERIOD: next_rdata = {24'h000000, timer_period};
                PMT_ADDR_COUNT: next_rdata = {24'h000000, count_value};
                PMT_ADDR_STATUS: next_rdata = {31'h00000000, match_flag};
                PMT_ADDR_IRQ_EN: next_rdata = {31'h00000000, match_irq_enable};
                default: next_rdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ready_q <= 1'b0;
            slverr_q <= 1'b0;
            rdata_q <= 32'h00000000;
        end else begin
            ready_q <= next_ready;
            slverr_q <= next_slverr;
            rdata_q <= next_rdata;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign pready = ready_q;
    assign prdata = rdata_q;
    assign pslverr = slverr_q;
    assign match_out = match_q;
    assign irq = irq_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_sleep_freeze: assert property (@(posedge pclk) disable iff (!presetn) // [R1]
        sleep_req && !wr |=> !match_q && $stable(count_value))
        else $error("count moved during sleep");
    a_sleep_period: assert property (@(posedge pclk) disable iff (!presetn) // [R2]
        sleep_req && !wr |=> $stable(timer_period))
        else $error("period moved during sleep");
    a_run_hold: assert property (@(posedge pclk) disable iff (!presetn) // [R12]
        !timer_run && !wr |=> $stable(count_value) && !match_q)
        else $error("count moved while stopped");
    a_bit7_zero: assert property (@(posedge pclk) disable iff (!presetn) // [R6]
        rd && paddr == PMT_ADDR_CONTROL |-> prdata[31:7] == 25'h0)
        else $error("control bit 7 not zero");
    a_match_wrap: assert property (@(posedge pclk) disable iff (!presetn) // [R8]
        match_now && !wr |=> count_value == 8'h00 && match_q)
        else $error("match did not wrap count");
    a_count_step: assert property (@(posedge pclk) disable iff (!presetn) // [R8]
        in_tick && !match_now && !wr |=> count_value == $past(count_value) + 8'h01)
        else $error("count did not step");
    a_flag_set: assert property (@(posedge pclk) disable iff (!presetn) // [R9]
        out_done |=> match_flag)
        else $error("flag not set on divider completion");
    a_ctrl_keep: assert property (@(posedge pclk) disable iff (!presetn) // [R11]
        wr && paddr == PMT_ADDR_CONTROL && !in_tick |=> $stable(count_value))
        else $error("control write disturbed count");
    a_irq_level: assert property (@(posedge pclk) disable iff (!presetn) // [R9]
        match_flag && match_irq_enable |-> irq)
        else $error("irq missing");
    a_ctrl_write: assert property (@(posedge pclk) disable iff (!presetn) // [R3] [R4] [R5] [R7]
        wr && paddr == PMT_ADDR_CONTROL |=> timer_control == $past(pwdata[6:0]))
        else $error("control write lost");
    a_sleep_tick: assert property (@(posedge pclk) disable iff (!presetn) // [R1]
        sleep_req |-> !in_tick && !out_done)
        else $error("tick during sleep");
    a_sleep_flag: assert property (@(posedge pclk) disable iff (!presetn) // [R1]
        sleep_req && !wr |=> $stable(match_flag))
        else $error("flag moved during sleep");
    a_run_tick: assert property (@(posedge pclk) disable iff (!presetn) // [R12]
        !timer_run |-> !in_tick && !match_now)
        else $error("tick while stopped");
    a_run_flag: assert property (@(posedge pclk) disable iff (!presetn) // [R12]
        !timer_run && !wr |=> $stable(match_flag))
        else $error("flag moved while stopped");
    a_div1_tick: assert property (@(posedge pclk) disable iff (!presetn) // [R5]
        active && input_divider_select == 2'b00 && !div_clear |-> in_tick)
        else $error("ratio one missed a tick");
    a_div_gap: assert property (@(posedge pclk) disable iff (!presetn) // [R5]
        in_tick && input_divider_select != 2'b00 |=> !in_tick)
        else $error("divided ticks too close");
    a_tick_match: assert property (@(posedge pclk) disable iff (!presetn) // [R8]
        match_now |-> in_tick && count_value == timer_period)
        else $error("match without equality");
    a_count_load: assert property (@(posedge pclk) disable iff (!presetn) // [R11]
        wr && paddr == PMT_ADDR_COUNT |=> count_value == $past(pwdata[7:0]))
        else $error("count write lost");
    a_clear_tick: assert property (@(posedge pclk) disable iff (!presetn) // [R11]
        div_clear |-> !in_tick && !out_done)
        else $error("divider advanced on clear");
    a_period_hold: assert property (@(posedge pclk) disable iff (!presetn) // [R2]
        !wr |=> $stable(timer_period))
        else $error("period moved without write");
    a_out_match: assert property (@(posedge pclk) disable iff (!presetn) // [R3]
        out_done |-> match_now)
        else $error("output divider done without match");
    a_out_one: assert property (@(posedge pclk) disable iff (!presetn) // [R3]
        output_divider_select == 4'h0 |-> out_done == match_now)
        else $error("ratio one output divider wrong");
    a_out_gap: assert property (@(posedge pclk) disable iff (!presetn) // [R3]
        out_done && output_divider_select != 4'h0 |=> !out_done)
        else $error("output divider done too soon");
    a_flag_sticky: assert property (@(posedge pclk) disable iff (!presetn) // [R9]
        match_flag && !(wr && paddr == PMT_ADDR_IRQ_CLR) |=> match_flag)
        else $error("flag lost without clear");
    a_flag_cause: assert property (@(posedge pclk) disable iff (!presetn) // [R9]
        !match_flag && !out_done |=> !match_flag)
        else $error("flag set without divider completion");
    a_irq_mask: assert property (@(posedge pclk) disable iff (!presetn) // [R9]
        !match_irq_enable |-> !irq)
        else $error("irq while disabled");
    a_irq_cause: assert property (@(posedge pclk) disable iff (!presetn) // [R9]
        !match_flag |-> !irq)
        else $error("irq without flag");

    // ------------------------------------------------------------
    // Bus checks
    // ------------------------------------------------------------
    a_ready_setup: assert property (@(posedge pclk) disable iff (!presetn)
        setup |=> pready)
        else $error("ready missing in access");
    a_ready_idle: assert property (@(posedge pclk) disable iff (!presetn)
        !setup |=> !pready)
        else $error("ready outside access");
    a_slverr_map: assert property (@(posedge pclk) disable iff (!presetn)
        setup && !known |=> pslverr)
        else $error("unmapped access not flagged");
endmodule // pmt_timer

/* File: shared/pmt_pkg.sv */
// Constants shared by the period match timer and its divider.
// Assumes an APB slave with 32-bit data, one register per aligned word.
package pmt_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] PMT_ADDR_CONTROL = 8'h00;
    localparam logic [7:0] PMT_ADDR_PERIOD = 8'h04;
    localparam logic [7:0] PMT_ADDR_COUNT = 8'h08;
    localparam logic [7:0] PMT_ADDR_STATUS = 8'h0c;
    localparam logic [7:0] PMT_ADDR_IRQ_EN = 8'h10;
    localparam logic [7:0] PMT_ADDR_IRQ_CLR = 8'h14;
    // ------------------------------------------------------------
    // Control fields
    // ------------------------------------------------------------
    localparam int PMT_OUTDIV_LSB = 3;
    localparam int PMT_OUTDIV_MSB = 6;
    localparam int PMT_RUN_BIT = 2;
    localparam int PMT_INDIV_LSB = 0;
    localparam int PMT_INDIV_MSB = 1;
    localparam logic [6:0] PMT_CONTROL_MASK = 7'h7f;
    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [6:0] PMT_CONTROL_RESET = 7'h00;
    localparam logic [7:0] PMT_COUNT_RESET = 8'h00;
    localparam logic [7:0] PMT_PERIOD_RESET = 8'hff;
    // ------------------------------------------------------------
    // Input divider terminal counts (ratio minus one)
    // ------------------------------------------------------------
    localparam logic [5:0] PMT_INDIV_TC_1 = 6'h00;
    localparam logic [5:0] PMT_INDIV_TC_4 = 6'h03;
    localparam logic [5:0] PMT_INDIV_TC_16 = 6'h0f;
    localparam logic [5:0] PMT_INDIV_TC_64 = 6'h3f;
endpackage

/* File: tb/tb_period_match_timer_8bit.sv */
// Self-checking bench for the period match timer: registers, divider timing,
// match flag interrupt, sleep freeze and reset values.
// Assumes pmt_timer with the APB register map of pmt_pkg.
`timescale 1ns/1ps
module tb_period_match_timer_8bit import pmt_pkg::*;;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic sleep_req = 1'b0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic match_out;
    logic irq;
    logic [31:0] rd;
    logic [31:0] cnt_a;
    logic er;
    int err_count = 0;
    int n_checks = 0;
    int cyc = 0;
    int t0;
    int n;
    int nsel[3] = '{0, 1, 15};

    pmt_timer dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sleep_req(sleep_req), .match_out(match_out), .irq(irq));

    // ------------------------------------------------------------
    // Clock, timeout and shared tasks
    // ------------------------------------------------------------
    always #5 pclk = ~pclk;

    // Longest test is the divide-by-64 interval; the ceiling leaves wide margin
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            err_count++;
            complete_run();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Waits an edge first so back-to-back calls never assign psel twice in one step
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(a, 1'b1, d);
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        xfer(a, 1'b0, 32'h0);
        check(rd, exp);
    endtask

    task automatic wait_match();
        @(posedge pclk);
        while (match_out !== 1'b1) @(posedge pclk);
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        rdchk(PMT_ADDR_CONTROL, 32'h0);
        rdchk(PMT_ADDR_PERIOD, 32'hff);
        rdchk(PMT_ADDR_COUNT, 32'h0);
        wr(PMT_ADDR_CONTROL, 32'hff);
        rdchk(PMT_ADDR_CONTROL, 32'h7f);
        xfer(8'h18, 1'b0, 32'h0);
        check({31'h0, er}, 32'h1);
        check(rd, 32'h0);
        wr(PMT_ADDR_CONTROL, 32'h78);
        wr(PMT_ADDR_COUNT, 32'h55);
        rdchk(PMT_ADDR_COUNT, 32'h55);
        wr(PMT_ADDR_CONTROL, 32'h7b);
        rdchk(PMT_ADDR_COUNT, 32'h55);
        rdchk(PMT_ADDR_CONTROL, 32'h7b);
        // Interval between matches is (period+1) times the input ratio
        wr(PMT_ADDR_PERIOD, 32'h01);
        for (int k = 0; k < 4; k++) begin
            wr(PMT_ADDR_CONTROL, 32'h04 | k);
            wait_match();
            t0 = cyc;
            wait_match();
            check(32'(cyc - t0), 32'h2 << (2 * k));
        end
        // Spacing of four cycles keeps the irq lag clear of the next match
        wr(PMT_ADDR_PERIOD, 32'h03);
        wr(PMT_ADDR_IRQ_EN, 32'h1);
        for (int i = 0; i < 3; i++) begin
            wr(PMT_ADDR_CONTROL, 32'(nsel[i]) << 3);
            wr(PMT_ADDR_IRQ_CLR, 32'h1);
            rdchk(PMT_ADDR_STATUS, 32'h0);
            wr(PMT_ADDR_CONTROL, (32'(nsel[i]) << 3) | 32'h4);
            n = 0;
            while (irq !== 1'b1) begin
                @(posedge pclk);
                if (match_out === 1'b1) n++;
            end
            check(32'(n), 32'(nsel[i] + 1));
        end
        wr(PMT_ADDR_CONTROL, 32'h0);
        wr(PMT_ADDR_IRQ_EN, 32'h0);
        repeat (2) @(posedge pclk);
        check({31'h0, irq}, 32'h0);
        rdchk(PMT_ADDR_STATUS, 32'h1);
        wr(PMT_ADDR_IRQ_CLR, 32'h1);
        rdchk(PMT_ADDR_STATUS, 32'h0);
        // Sleep while running: nothing may move until wake
        wr(PMT_ADDR_CONTROL, 32'h04);
        repeat (3) @(posedge pclk);
        sleep_req <= 1'b1;
        xfer(PMT_ADDR_COUNT, 1'b0, 32'h0);
        cnt_a = rd;
        n = 0;
        repeat (40) begin
            @(posedge pclk);
            if (match_out === 1'b1) n++;
        end
        check(32'(n), 32'h0);
        rdchk(PMT_ADDR_COUNT, cnt_a);
        rdchk(PMT_ADDR_PERIOD, 32'h03);
        @(posedge pclk);
        sleep_req <= 1'b0;
        wait_match();
        // Second reset in mid-run
        wr(PMT_ADDR_COUNT, 32'h34);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rdchk(PMT_ADDR_PERIOD, 32'hff);
        rdchk(PMT_ADDR_COUNT, 32'h0);
        rdchk(PMT_ADDR_CONTROL, 32'h0);
        complete_run();
    end
endmodule // tb_period_match_timer_8bit
